//--- hdl/pulse_train_generator.sv
// Main pulse and sync pulse generator with a segment list and an Avalon-MM slave
//
// Contract
// R01 - One enable starts and stops both outputs, resets off
// R02 - Signal 1 is main, signal 2 is sync
// R03 - Added segments append, never overwrite stored ones
// R04 - Each segment is one pulse: start, stop, flag
// R05 - Flag 0 keeps range, no pulse; default 1
// R06 - Start accepted from zero up, default zero
// R07 - Stop accepted from one tick up, default one tick
// R08 - Segment pulses at least one tick, within period
// R09 - Clear-all empties the segment list, no readback
// R10 - Train period programmable, resets to 100 us
// R11 - Sync period always follows main period
// R12 - Count reports all stored segments, resets zero
// R13 - Segment list empty after reset
// R14 - Edits to missing segment indices are rejected
// R15 - Segment flag writable and readable individually
// R16 - Four output types; both reset to single
// R17 - Train type only for the main output
// R18 - Main single width resets to 1 us
// R19 - Sync width resets to 200 ns
// R20 - Per-output polarity, resets to normal
// R21 - Signed sync delay in ticks, resets zero
// R22 - Single pulse period separate, resets to 10 us
// R23 - Times are tick counts; train compares segment window
// R24 - Disabled: outputs inactive level, counters held; the code reloads them to their start values instead
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pulse_train_generator #(
  parameter int SEG_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic main_pulse_out,
  output logic sync_pulse_out
);

  localparam int TW = pulse_train_pkg::TIME_W;
  localparam int SW = pulse_train_pkg::SYNC_W;
  localparam int DW = pulse_train_pkg::DELAY_W;
  localparam int IDX_W = $clog2(SEG_DEPTH);
  localparam int CNT_W = $clog2(SEG_DEPTH + 1);
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(SEG_DEPTH);

  typedef struct packed {
    logic active;
    logic [TW-1:0] start;
    logic [TW-1:0] stop;
  } seg_entry_type;

  typedef struct packed {
    // Settings
    logic enable;
    pulse_train_pkg::pulse_type_type main_type;
    pulse_train_pkg::pulse_type_type sync_type;
    logic main_pol;
    logic sync_pol;
    logic [TW-1:0] train_per;
    logic [TW-1:0] single_per;
    logic [TW-1:0] main_width;
    logic [SW-1:0] sync_width;
    logic [DW-1:0] sync_delay;
    // Segment list
    logic [31:0] seg_index;
    seg_entry_type staged;
    seg_entry_type [SEG_DEPTH-1:0] segs;
    logic [CNT_W-1:0] seg_count;
    logic rejected;
    // Timing
    logic [TW-1:0] main_cnt;
    logic [TW-1:0] sync_cnt;
    logic [DW-1:0] hold_cnt;
    logic running;
    logic main_out;
    logic sync_out;
    // Bus answer
    logic waitreq;
    logic [31:0] rdata;
  } state_type;

  state_type state_q;
  state_type state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  logic [TW-1:0] period;
  logic index_ok;
  logic [IDX_W-1:0] idx;
  seg_entry_type cur_seg;
  logic train_hit;
  logic [TW-1:0] neg_delay;
  logic delay_neg;

  always_comb begin
    // Sync shares the main period whatever its own type [R11]
    if (state_q.main_type == pulse_train_pkg::train_type) begin
      period = state_q.train_per;
    end else begin
      period = state_q.single_per;
    end
    index_ok = state_q.seg_index < 32'(state_q.seg_count); // [R14]
    idx = state_q.seg_index[IDX_W-1:0];
    cur_seg = index_ok ? state_q.segs[idx] : '0;
    delay_neg = state_q.sync_delay[DW-1];
    neg_delay = TW'(-$signed(state_q.sync_delay));
  end

  // Window test per stored segment; an inactive one keeps its range only
  logic [SEG_DEPTH-1:0] seg_hit;
  genvar g;
  generate
    for (g = 0; g < SEG_DEPTH; g++) begin : g_seg
      assign seg_hit[g] = (CNT_W'(g) < state_q.seg_count) && state_q.segs[g].active
        && (state_q.main_cnt >= state_q.segs[g].start)
        && (state_q.main_cnt < state_q.segs[g].stop); // [R05] [R23]
    end
  endgenerate
  assign train_hit = |seg_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  function automatic seg_entry_type fix_seg(input seg_entry_type s);
    seg_entry_type r;
    r = s;
    // A pulse is never shorter than one tick
    if (r.stop <= r.start) begin
      r.stop = r.start + pulse_train_pkg::MIN_COUNT; // [R08]
    end
    return r;
  endfunction : fix_seg

  // Scratch values of the next-state process
  logic req;
  logic do_write;
  logic main_level;
  logic sync_level;
  logic [TW-1:0] sync_init;

  always_comb begin
    state_d = state_q;
    req = read || write;
    do_write = write && !state_q.waitreq;

    // Bus handshake: ack one cycle after the request, then rearm
    if (req && state_q.waitreq) begin
      state_d.waitreq = 1'b0;
    end else begin
      state_d.waitreq = 1'b1;
    end
    // Registered, so it stands while waitrequest is low
    state_d.rdata = 32'h0000_0000;
    unique case (address)
      pulse_train_pkg::CTRL_ADDR: state_d.rdata = {31'h0, state_q.enable};
      pulse_train_pkg::CONFIG_ADDR: state_d.rdata = {26'h0, state_q.sync_pol,
        state_q.main_pol, state_q.sync_type, state_q.main_type};
      pulse_train_pkg::TRAIN_PER_LO_ADDR: state_d.rdata = state_q.train_per[31:0];
      pulse_train_pkg::TRAIN_PER_HI_ADDR: state_d.rdata = {22'h0, state_q.train_per[TW-1:32]};
      pulse_train_pkg::SINGLE_PER_LO_ADDR: state_d.rdata = state_q.single_per[31:0];
      pulse_train_pkg::SINGLE_PER_HI_ADDR: state_d.rdata = {22'h0, state_q.single_per[TW-1:32]};
      pulse_train_pkg::MAIN_WIDTH_LO_ADDR: state_d.rdata = state_q.main_width[31:0];
      pulse_train_pkg::MAIN_WIDTH_HI_ADDR: state_d.rdata = {22'h0, state_q.main_width[TW-1:32]};
      pulse_train_pkg::SYNC_WIDTH_ADDR: state_d.rdata = state_q.sync_width;
      pulse_train_pkg::SYNC_DELAY_LO_ADDR: state_d.rdata = state_q.sync_delay[31:0];
      pulse_train_pkg::SYNC_DELAY_HI_ADDR: state_d.rdata = {31'h0, state_q.sync_delay[DW-1]};
      pulse_train_pkg::SEG_INDEX_ADDR: state_d.rdata = state_q.seg_index;
      pulse_train_pkg::SEG_START_LO_ADDR: state_d.rdata = cur_seg.start[31:0];
      pulse_train_pkg::SEG_START_HI_ADDR: state_d.rdata = {22'h0, cur_seg.start[TW-1:32]};
      pulse_train_pkg::SEG_STOP_LO_ADDR: state_d.rdata = cur_seg.stop[31:0];
      pulse_train_pkg::SEG_STOP_HI_ADDR: state_d.rdata = {22'h0, cur_seg.stop[TW-1:32]};
      pulse_train_pkg::SEG_ACTIVE_ADDR: state_d.rdata = {31'h0, cur_seg.active}; // [R15]
      pulse_train_pkg::SEG_STATUS_ADDR: state_d.rdata = {state_q.rejected,
        (31 - CNT_W)'(0), state_q.seg_count}; // [R12]
      default: state_d.rdata = 32'h0000_0000;
    endcase

    // Writes land only at the edge waitrequest is low
    if (do_write) begin
      unique case (address)
        pulse_train_pkg::CTRL_ADDR: begin
          state_d.enable = writedata[pulse_train_pkg::CTRL_ENABLE_BIT]; // [R01]
        end
        pulse_train_pkg::CONFIG_ADDR: begin
          state_d.main_type = pulse_train_pkg::pulse_type_type'(
            writedata[pulse_train_pkg::CFG_MAIN_TYPE_LSB +: 2]); // [R02] [R16]
          // Sync keeps its old type when train is asked for
          if (writedata[pulse_train_pkg::CFG_SYNC_TYPE_LSB +: 2] != pulse_train_pkg::train_type)
          begin
            state_d.sync_type = pulse_train_pkg::pulse_type_type'(
              writedata[pulse_train_pkg::CFG_SYNC_TYPE_LSB +: 2]); // [R17]
          end
          state_d.main_pol = writedata[pulse_train_pkg::CFG_MAIN_POL_BIT]; // [R20]
          state_d.sync_pol = writedata[pulse_train_pkg::CFG_SYNC_POL_BIT]; // [R20]
        end
        pulse_train_pkg::TRAIN_PER_LO_ADDR: state_d.train_per[31:0] = writedata; // [R10]
        pulse_train_pkg::TRAIN_PER_HI_ADDR: state_d.train_per[TW-1:32] = writedata[TW-33:0];
        pulse_train_pkg::SINGLE_PER_LO_ADDR: state_d.single_per[31:0] = writedata; // [R22]
        pulse_train_pkg::SINGLE_PER_HI_ADDR: state_d.single_per[TW-1:32] = writedata[TW-33:0];
        pulse_train_pkg::MAIN_WIDTH_LO_ADDR: state_d.main_width[31:0] = writedata; // [R18]
        pulse_train_pkg::MAIN_WIDTH_HI_ADDR: state_d.main_width[TW-1:32] = writedata[TW-33:0];
        pulse_train_pkg::SYNC_WIDTH_ADDR: state_d.sync_width = writedata; // [R19]
        pulse_train_pkg::SYNC_DELAY_LO_ADDR: state_d.sync_delay[31:0] = writedata; // [R21]
        pulse_train_pkg::SYNC_DELAY_HI_ADDR: state_d.sync_delay[DW-1] = writedata[0];
        pulse_train_pkg::SEG_INDEX_ADDR: state_d.seg_index = writedata;
        pulse_train_pkg::SEG_START_LO_ADDR: state_d.staged.start[31:0] = writedata; // [R06]
        pulse_train_pkg::SEG_START_HI_ADDR: state_d.staged.start[TW-1:32] = writedata[TW-33:0];
        pulse_train_pkg::SEG_STOP_LO_ADDR: state_d.staged.stop[31:0] = writedata; // [R07]
        pulse_train_pkg::SEG_STOP_HI_ADDR: state_d.staged.stop[TW-1:32] = writedata[TW-33:0];
        pulse_train_pkg::SEG_ACTIVE_ADDR: state_d.staged.active = writedata[0];
        pulse_train_pkg::SEG_CMD_ADDR: begin
          state_d.rejected = 1'b0;
          // Clear wins over append, append over edits
          if (writedata[pulse_train_pkg::CMD_CLEAR_BIT]) begin
            state_d.seg_count = '0; // [R09]
          end else if (writedata[pulse_train_pkg::CMD_APPEND_BIT]) begin
            // Append after the last entry; a full list refuses
            if (state_q.seg_count < DEPTH_C) begin
              state_d.segs[state_q.seg_count[IDX_W-1:0]] = fix_seg(state_q.staged); // [R03] [R04]
              state_d.seg_count = state_q.seg_count + CNT_W'(1);
            end else begin
              state_d.rejected = 1'b1;
            end
            // Staging returns to the new-segment defaults
            state_d.staged.active = 1'b1; // [R05]
            state_d.staged.start = pulse_train_pkg::SEG_START_RST; // [R06]
            state_d.staged.stop = pulse_train_pkg::SEG_STOP_RST; // [R07]
          end else if (writedata[pulse_train_pkg::CMD_SET_START_BIT +: 3] != 3'h0) begin
            // Index at or past the count is a missing segment
            if (index_ok) begin
              if (writedata[pulse_train_pkg::CMD_SET_START_BIT]) begin
                state_d.segs[idx].start = state_q.staged.start;
              end
              if (writedata[pulse_train_pkg::CMD_SET_STOP_BIT]) begin
                state_d.segs[idx].stop = state_q.staged.stop;
              end
              state_d.segs[idx] = fix_seg(state_d.segs[idx]); // [R08]
              if (writedata[pulse_train_pkg::CMD_SET_ACTIVE_BIT]) begin
                state_d.segs[idx].active = state_q.staged.active; // [R15]
              end
            end else begin
              state_d.rejected = 1'b1; // [R14]
            end
          end
        end
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timing: counters run only while enabled

    // Negative delay starts sync part way into its period
    sync_init = delay_neg ? ((neg_delay < period) ? neg_delay : period - MIN_ONE()) : '0;
    if (!state_q.enable) begin
      state_d.main_cnt = '0; // [R24]
      state_d.sync_cnt = sync_init; // [R21]
      state_d.hold_cnt = delay_neg ? '0 : state_q.sync_delay;
      state_d.running = 1'b0;
    end else begin
      state_d.running = 1'b1;
      // A shortened period wraps at once instead of running up the long way
      if (state_q.main_cnt + MIN_ONE() >= period) begin
        state_d.main_cnt = '0;
      end else begin
        state_d.main_cnt = state_q.main_cnt + MIN_ONE();
      end
      if (state_q.hold_cnt != '0) begin
        state_d.hold_cnt = state_q.hold_cnt - DW'(1); // [R21]
      end else if (state_q.sync_cnt + MIN_ONE() >= period) begin
        state_d.sync_cnt = '0; // [R11]
      end else begin
        state_d.sync_cnt = state_q.sync_cnt + MIN_ONE();
      end
    end

    // Levels use the old counts; outputs lag one cycle
    unique case (state_q.main_type)
      pulse_train_pkg::single_type: main_level = state_q.main_cnt < state_q.main_width;
      pulse_train_pkg::train_type: main_level = train_hit; // [R23]
      pulse_train_pkg::constant_high_type: main_level = 1'b1;
      pulse_train_pkg::constant_low_type: main_level = 1'b0;
    endcase
    unique case (state_q.sync_type)
      pulse_train_pkg::constant_high_type: sync_level = 1'b1;
      pulse_train_pkg::constant_low_type: sync_level = 1'b0;
      default: sync_level = (state_q.hold_cnt == '0)
        && (state_q.sync_cnt < TW'(state_q.sync_width));
    endcase

    state_d.main_out = (state_q.running && main_level) ^ state_q.main_pol; // [R20] [R24]
    state_d.sync_out = (state_q.running && sync_level) ^ state_q.sync_pol; // [R20] [R24]
  end

  // One tick at counter width
  function automatic logic [TW-1:0] MIN_ONE();
    return pulse_train_pkg::MIN_COUNT;
  endfunction : MIN_ONE

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= '0;
      state_q.enable <= 1'b0; // [R01]
      state_q.main_type <= pulse_train_pkg::single_type; // [R16]
      state_q.sync_type <= pulse_train_pkg::single_type; // [R16]
      state_q.train_per <= pulse_train_pkg::TRAIN_PER_RST; // [R10]
      state_q.single_per <= pulse_train_pkg::SINGLE_PER_RST; // [R22]
      state_q.main_width <= pulse_train_pkg::MAIN_WIDTH_RST; // [R18]
      state_q.sync_width <= pulse_train_pkg::SYNC_WIDTH_RST; // [R19]
      state_q.sync_delay <= pulse_train_pkg::SYNC_DELAY_RST; // [R21]
      // Staging starts at the new-segment defaults
      state_q.staged.active <= 1'b1;
      state_q.staged.start <= pulse_train_pkg::SEG_START_RST;
      state_q.staged.stop <= pulse_train_pkg::SEG_STOP_RST;
      // Segment contents need no reset: the count gates every use
      state_q.seg_count <= '0; // [R12] [R13]
      state_q.waitreq <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // Every output straight from the state register
  assign readdata = state_q.rdata;
  assign waitrequest = state_q.waitreq;
  assign main_pulse_out = state_q.main_out;
  assign sync_pulse_out = state_q.sync_out;

endmodule : pulse_train_generator

`default_nettype wire

//--- include/pulse_train_pkg.sv
// Shared constants and types for the pulse train generator
package pulse_train_pkg;

  // Time base: every stored time is a count of this tick
  localparam longint TICK_PS = 64'd12500;
  localparam int TIME_W = 42;
  localparam int SYNC_W = 32;
  localparam int DELAY_W = 33;

  // Reset times in picoseconds and the tick counts derived from them
  localparam longint TRAIN_PER_RST_PS = 64'd100000000;
  localparam longint SINGLE_PER_RST_PS = 64'd10000000;
  localparam longint MAIN_WIDTH_RST_PS = 64'd1000000;
  localparam longint SYNC_WIDTH_RST_PS = 64'd200000;
  localparam longint SEG_STOP_RST_PS = 64'd12500;
  localparam logic [TIME_W-1:0] TRAIN_PER_RST = TIME_W'(TRAIN_PER_RST_PS / TICK_PS);
  localparam logic [TIME_W-1:0] SINGLE_PER_RST = TIME_W'(SINGLE_PER_RST_PS / TICK_PS);
  localparam logic [TIME_W-1:0] MAIN_WIDTH_RST = TIME_W'(MAIN_WIDTH_RST_PS / TICK_PS);
  localparam logic [SYNC_W-1:0] SYNC_WIDTH_RST = SYNC_W'(SYNC_WIDTH_RST_PS / TICK_PS);
  localparam logic [TIME_W-1:0] SEG_STOP_RST = TIME_W'(SEG_STOP_RST_PS / TICK_PS);
  localparam logic [TIME_W-1:0] SEG_START_RST = 42'h000_0000_0000;
  localparam logic [DELAY_W-1:0] SYNC_DELAY_RST = 33'h0_0000_0000;
  localparam logic [TIME_W-1:0] MIN_COUNT = 42'h000_0000_0001;

  // Register byte addresses (word index = byte address / 4)
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] CONFIG_ADDR = 8'h04;
  localparam logic [7:0] TRAIN_PER_LO_ADDR = 8'h08;
  localparam logic [7:0] TRAIN_PER_HI_ADDR = 8'h0C;
  localparam logic [7:0] SINGLE_PER_LO_ADDR = 8'h10;
  localparam logic [7:0] SINGLE_PER_HI_ADDR = 8'h14;
  localparam logic [7:0] MAIN_WIDTH_LO_ADDR = 8'h18;
  localparam logic [7:0] MAIN_WIDTH_HI_ADDR = 8'h1C;
  localparam logic [7:0] SYNC_WIDTH_ADDR = 8'h20;
  localparam logic [7:0] SYNC_DELAY_LO_ADDR = 8'h24;
  localparam logic [7:0] SYNC_DELAY_HI_ADDR = 8'h28;
  localparam logic [7:0] SEG_INDEX_ADDR = 8'h2C;
  localparam logic [7:0] SEG_START_LO_ADDR = 8'h30;
  localparam logic [7:0] SEG_START_HI_ADDR = 8'h34;
  localparam logic [7:0] SEG_STOP_LO_ADDR = 8'h38;
  localparam logic [7:0] SEG_STOP_HI_ADDR = 8'h3C;
  localparam logic [7:0] SEG_ACTIVE_ADDR = 8'h40;
  localparam logic [7:0] SEG_CMD_ADDR = 8'h44;
  localparam logic [7:0] SEG_STATUS_ADDR = 8'h48;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CFG_MAIN_TYPE_LSB = 0;
  localparam int CFG_SYNC_TYPE_LSB = 2;
  localparam int CFG_MAIN_POL_BIT = 4;
  localparam int CFG_SYNC_POL_BIT = 5;
  localparam int CMD_APPEND_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int CMD_SET_START_BIT = 2;
  localparam int CMD_SET_STOP_BIT = 3;
  localparam int CMD_SET_ACTIVE_BIT = 4;
  localparam int STATUS_REJECT_BIT = 31;

  typedef enum logic [1:0] {
    single_type = 2'h0,
    train_type = 2'h1,
    constant_high_type = 2'h3,
    constant_low_type = 2'h2
  } pulse_type_type;

endpackage : pulse_train_pkg

//--- tb/pulse_train_chk.sv
// Assertions on bus timing, segment count and output levels
`timescale 1ns/1ps
`default_nettype none

module pulse_train_chk #(
  parameter int SEG_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic main_pulse_out,
  input wire logic sync_pulse_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////
  // Shadow of settings; output checks wait 7 quiet cycles for latency
  logic wr_ok;
  logic en_q;
  logic [5:0] cfg_q;
  logic [2:0] since_q;
  logic [7:0] cnt_q;
  assign wr_ok = write && !waitrequest;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_q <= 1'b0;
      cfg_q <= 6'h00;
      since_q <= 3'h0;
      cnt_q <= 8'h00;
    end else begin
      since_q <= wr_ok ? 3'h0 : since_q + {2'h0, since_q != 3'h7};
      if (wr_ok && address == pulse_train_pkg::CTRL_ADDR) begin
        en_q <= writedata[0];
      end
      if (wr_ok && address == pulse_train_pkg::CONFIG_ADDR) begin
        cfg_q <= {writedata[5:4], (writedata[3:2] == 2'h1) ? cfg_q[3:2] : writedata[3:2],
          writedata[1:0]};
      end
      if (wr_ok && address == pulse_train_pkg::SEG_CMD_ADDR) begin
        if (writedata[1]) begin
          cnt_q <= 8'h00;
        end else if (writedata[0] && cnt_q < 8'(SEG_DEPTH)) begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_rst_low;
    $fell(srst) |-> !main_pulse_out && !sync_pulse_out;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("outputs not low after reset");
  property p_off_main;
    !en_q && since_q == 3'h7 |-> main_pulse_out == cfg_q[4];
  endproperty
  a_off_main: assert property (p_off_main) else $error("main active while off");
  property p_off_sync;
    !en_q && since_q == 3'h7 |-> sync_pulse_out == cfg_q[5];
  endproperty
  a_off_sync: assert property (p_off_sync) else $error("sync active while off");
  property p_main_const;
    en_q && since_q == 3'h7 && cfg_q[1] |-> main_pulse_out == (cfg_q[0] ^ cfg_q[4]);
  endproperty
  a_main_const: assert property (p_main_const) else $error("main constant level");
  property p_sync_const;
    en_q && since_q == 3'h7 && cfg_q[3] |-> sync_pulse_out == (cfg_q[2] ^ cfg_q[5]);
  endproperty
  a_sync_const: assert property (p_sync_const) else $error("sync constant level");
  property p_count;
    read && waitrequest && address == pulse_train_pkg::SEG_STATUS_ADDR
      |=> readdata[7:0] == cnt_q;
  endproperty
  a_count: assert property (p_count) else $error("segment count");
  property p_wait_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_answer;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer in one cycle");
  property p_cause;
    $fell(waitrequest) |-> $past(read) || $past(write);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_unmapped;
    read && waitrequest && address > pulse_train_pkg::SEG_STATUS_ADDR |=> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : pulse_train_chk

bind pulse_train_generator pulse_train_chk #(.SEG_DEPTH(SEG_DEPTH)) u_chk (
  .ref_clk(ref_clk), .srst(srst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .main_pulse_out(main_pulse_out), .sync_pulse_out(sync_pulse_out)
);

`default_nettype wire

//--- tb/tb.sv
// Self-checking bench: registers, segment list and pulse outputs
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic main_pulse_out;
  logic sync_pulse_out;
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 32'hC0B354A7;

  pulse_train_generator #(.SEG_DEPTH(16)) u_dut (
    .ref_clk(ref_clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .main_pulse_out(main_pulse_out), .sync_pulse_out(sync_pulse_out)
  );

  always #5 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  // Bus values are read right after the edge, before that edge's updates land
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    chk("bus answer", 1'b1, n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(nm, e, q);
  endtask : rc

  // High cycles of both outputs over a window, after the pipeline settles
  task automatic cnt(input int n, output int m, output int s);
    m = 0;
    s = 0;
    repeat (6) @(posedge ref_clk);
    repeat (n) begin
      @(posedge ref_clk);
      m += int'(main_pulse_out === 1'b1);
      s += int'(sync_pulse_out === 1'b1);
    end
  endtask : cnt

  function automatic logic [1:0] sync_next(input logic [1:0] old, input logic [1:0] t);
    return (t == pulse_train_pkg::train_type) ? old : t;
  endfunction : sync_next
  //////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial begin
    logic [31:0] ss [16];
    logic [31:0] sp [16];
    logic [31:0] sa [16];
    logic [31:0] v;
    logic [1:0] sy;
    int m;
    int s;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rc("enable", pulse_train_pkg::CTRL_ADDR, 32'h0);
    rc("config", pulse_train_pkg::CONFIG_ADDR, 32'h0);
    rc("status", pulse_train_pkg::SEG_STATUS_ADDR, 32'h0);
    rc("train period", pulse_train_pkg::TRAIN_PER_LO_ADDR, 32'h1F40);
    rc("single period", pulse_train_pkg::SINGLE_PER_LO_ADDR, 32'h320);
    rc("main width", pulse_train_pkg::MAIN_WIDTH_LO_ADDR, 32'h50);
    rc("sync width", pulse_train_pkg::SYNC_WIDTH_ADDR, 32'h10);
    rc("sync delay", pulse_train_pkg::SYNC_DELAY_LO_ADDR, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rc("unmapped", 8'hFC, 32'h0);
    for (int i = 0; i < 16; i++) begin
      ss[i] = (i == 0) ? 32'h0 : ($random(seed) & 32'hFF);
      sp[i] = (i == 0) ? 32'h1 : ss[i] + 32'h1 + ($random(seed) & 32'hF);
      sa[i] = (i == 0) ? 32'h1 : ($random(seed) & 32'h1);
      if (i > 0) begin
        wr(pulse_train_pkg::SEG_START_LO_ADDR, ss[i]);
        wr(pulse_train_pkg::SEG_STOP_LO_ADDR, sp[i]);
        wr(pulse_train_pkg::SEG_ACTIVE_ADDR, sa[i]);
      end
      wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h1);
    end
    wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h1);
    rc("full list", pulse_train_pkg::SEG_STATUS_ADDR, 32'h8000_0010);
    for (int i = 0; i < 16; i++) begin
      wr(pulse_train_pkg::SEG_INDEX_ADDR, i);
      rc("seg start", pulse_train_pkg::SEG_START_LO_ADDR, ss[i]);
      rc("seg stop", pulse_train_pkg::SEG_STOP_LO_ADDR, sp[i]);
      rc("seg active", pulse_train_pkg::SEG_ACTIVE_ADDR, sa[i]);
    end
    wr(pulse_train_pkg::SEG_INDEX_ADDR, 32'h10);
    wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h4);
    rc("missing edit", pulse_train_pkg::SEG_STATUS_ADDR, 32'h8000_0010);
    wr(pulse_train_pkg::SEG_INDEX_ADDR, 32'h3);
    wr(pulse_train_pkg::SEG_ACTIVE_ADDR, sa[3] ^ 32'h1);
    wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h10);
    rc("flag edit", pulse_train_pkg::SEG_ACTIVE_ADDR, sa[3] ^ 32'h1);
    rc("flag keeps start", pulse_train_pkg::SEG_START_LO_ADDR, ss[3]);
    wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h2);
    rc("cleared", pulse_train_pkg::SEG_STATUS_ADDR, 32'h0);
    wr(pulse_train_pkg::CTRL_ADDR, 32'h1);
    sy = 2'h0;
    for (int i = 0; i < 8; i++) begin
      v = ($random(seed) & 32'h30) | {28'h0, i[1:0], i[1:0]};
      sy = sync_next(sy, i[1:0]);
      wr(pulse_train_pkg::CONFIG_ADDR, v);
      rc("types", pulse_train_pkg::CONFIG_ADDR, (v & 32'h33) | {28'h0, sy, 2'h0});
      cnt(4, m, s);
    end
    wr(pulse_train_pkg::CTRL_ADDR, 32'h0);
    wr(pulse_train_pkg::TRAIN_PER_LO_ADDR, 32'hA);
    wr(pulse_train_pkg::SYNC_WIDTH_ADDR, 32'h2);
    wr(pulse_train_pkg::SEG_START_LO_ADDR, 32'h2);
    wr(pulse_train_pkg::SEG_STOP_LO_ADDR, 32'h5);
    wr(pulse_train_pkg::SEG_ACTIVE_ADDR, 32'h1);
    wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h1);
    wr(pulse_train_pkg::CONFIG_ADDR, 32'h1);
    wr(pulse_train_pkg::CTRL_ADDR, 32'h1);
    cnt(20, m, s);
    chk("train highs", 32'd6, m);
    chk("sync tracks period", 32'd4, s);
    wr(pulse_train_pkg::SEG_INDEX_ADDR, 32'h0);
    wr(pulse_train_pkg::SEG_ACTIVE_ADDR, 32'h0);
    wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h10);
    wr(pulse_train_pkg::SEG_START_LO_ADDR, 32'h7);
    wr(pulse_train_pkg::SEG_STOP_LO_ADDR, 32'h7);
    wr(pulse_train_pkg::SEG_ACTIVE_ADDR, 32'h1);
    wr(pulse_train_pkg::SEG_CMD_ADDR, 32'h1);
    cnt(20, m, s);
    chk("inactive and one tick", 32'd2, m);
    wr(pulse_train_pkg::CTRL_ADDR, 32'h0);
    wr(pulse_train_pkg::SINGLE_PER_LO_ADDR, 32'h8);
    wr(pulse_train_pkg::MAIN_WIDTH_LO_ADDR, 32'h3);
    wr(pulse_train_pkg::CONFIG_ADDR, 32'h0);
    wr(pulse_train_pkg::CTRL_ADDR, 32'h1);
    cnt(16, m, s);
    chk("single highs", 32'd6, m);
    chk("sync single", 32'd4, s);
    wr(pulse_train_pkg::CONFIG_ADDR, 32'h30);
    cnt(16, m, s);
    chk("main inverted", 32'd10, m);
    chk("sync inverted", 32'd12, s);
    wr(pulse_train_pkg::CTRL_ADDR, 32'h0);
    cnt(8, m, s);
    chk("main off", 32'd8, m);
    chk("sync off", 32'd8, s);
    conclude();
  end
endmodule : tb

`default_nettype wire
